// ===== dv/sfa_issuer.sv
`timescale 1ns/10ps
// Sequencer stand-in: one operation per call, released code, operand and carry-in lines never keep their last value
module sfa_issuer (
    input wire logic clk, // Clock shared with the unit
    output logic vld, // Operation strobe
    output logic [4:0] code, // Operation code
    output logic [15:0] a, // Short operand one
    output logic [15:0] b, // Short operand two or count
    output logic [31:0] la, // Long operand or accumulator
    output logic [31:0] lb, // Long operand two
    output logic ci, // Carry into wrapping ops
    output logic fw, // Flag write strobe
    output logic cw, // Carry value to write
    output logic ow // Overflow value to write
);
    // Defined levels from time zero
    initial begin
        {vld, code, a, b, la, lb, ci, fw, cw, ow} = '0;
    end

    // Strobe and operands change together just after an edge
    task automatic issue(input logic [4:0] c, input logic [15:0] x, input logic [15:0] y,
                         input logic [31:0] lx, input logic [31:0] ly, input logic [3:0] f);
        @(posedge clk);
        vld <= 1'b1;
        {code, a, b, la, lb} <= {c, x, y, lx, ly};
        {ci, fw, cw, ow} <= f;
    endtask : issue

    // Idle code, operand and carry-in lines are inverted so a unit that samples them late gets garbage
    task automatic idle();
        @(posedge clk);
        {vld, fw} <= 2'b00;
        {code, a, b, la, lb, ci} <= ~{code, a, b, la, lb, ci};
    endtask : idle
endmodule : sfa_issuer

// ===== dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic mclk, rst_n, clk_en, sync_clr, rnd_ctl;
    logic vld, ci, fw, cw, ow, res_v, carry, ovf;
    logic [4:0] code;
    logic [15:0] a, b;
    logic [31:0] la, lb, res, e_res;
    logic e_v, e_cy, e_ov, cy, ov, w;
    longint r;
    int e_c, mismatches, checks_done;
    logic [15:0] cs[4] = '{16'h8000, 16'h7fff, 16'h0000, 16'hffff};
    logic [31:0] cl[4] = '{32'h80000000, 32'h7fffffff, 32'h00000000, 32'hffffffff};

    sfa_issuer u_iss (.clk(mclk), .vld(vld), .code(code), .a(a), .b(b), .la(la), .lb(lb),
                      .ci(ci), .fw(fw), .cw(cw), .ow(ow));
    sfa_alu u_dut (.MCLK(mclk), .RST_N(rst_n), .CLK_EN(clk_en), .SYNC_CLR(sync_clr), .OP_VALID(vld),
                   .OP_CODE(code), .OPA(a), .OPB(b), .LOPA(la), .LOPB(lb), .CARRY_IN(ci), .FLAG_WR(fw),
                   .CARRY_WR(cw), .OVF_WR(ow), .RES_VALID(res_v), .RES(res), .CARRY(carry), .OVERFLOW(ovf));

    // Clamp to a signed range of w bits
    function automatic longint sat(longint x, int w);
        longint mx = (64'sd1 <<< (w - 1)) - 1;
        if (x > mx) return mx;
        if (x < -mx - 1) return -mx - 1;
        return x;
    endfunction : sat

    // Counts past the width are settled first, so the shift itself never loses bits
    function automatic longint shl(longint x, longint n, int w);
        if (n < 0) return (-n >= w) ? (x < 0 ? -1 : 0) : x >>> -n;
        if (n >= w) return (x == 0) ? 0 : sat((x < 0) ? -(64'sd1 <<< 40) : (64'sd1 <<< 40), w);
        return sat(x <<< n, w);
    endfunction : shl

    function automatic longint nrm(longint x, int w);
        int n = 0;
        if (x == 0) return 0;
        if (x == -1) return w - 1;
        while (x < (64'sd1 <<< (w - 2)) && x >= -(64'sd1 <<< (w - 2))) begin
            x = x * 2;
            n++;
        end
        return n;
    endfunction : nrm

    // Reference result in wide integers; the caller keeps 32 bits
    function automatic longint model(int c, longint a, longint b, longint la, longint lb, bit ci,
                                     output bit cy, output bit ov, output bit w);
        longint p, f, t, s;
        p = a * b;
        f = (p == 64'sd1073741824) ? 64'sd2147483647 : 2 * p;
        t = (c == 24) ? -f - 1 : f;
        s = la + t + ci;
        cy = 1'(((la & 64'hffffffff) + (t & 64'hffffffff) + ci) >> 32);
        ov = (s != sat(s, 32));
        w = (c == 23 || c == 24);
        case (c)
            0: return sat(a + b, 16);
            1: return sat(a - b, 16);
            2: return sat(a < 0 ? -a : a, 16);
            3: return shl(a, b, 16);
            4: return shl(a, -b, 16);
            5: return sat(-a, 16);
            6: return (a > b) ? a : b;
            7: return (a < b) ? a : b;
            8: return nrm(a, 16);
            9: return sat(la + lb, 32);
            10: return sat(la - lb, 32);
            11: return sat(-la, 32);
            12: return shl(la, b, 32);
            13: return shl(la, -b, 32);
            14: return nrm(la, 32);
            15: return f;
            16: return p;
            17: return sat(p >>> 15, 16);
            18: return sat((p + 16384) >>> 15, 16);
            19: return sat(la + f, 32);
            20: return sat(la - f, 32);
            21: return sat(la + p, 32);
            22: return sat(la - p, 32);
            23, 24: return s;
            25: return sat(sat(la + f, 32) + 32768, 32) >>> 16;
            26: return sat(sat(la - f, 32) + 32768, 32) >>> 16;
            27: return la >>> 16;
            28: return ((la & 16'hffff) ^ 32768) - 32768;
            29: return sat(la + 32768, 32) >>> 16;
            default: return 0;
        endcase
    endfunction : model

    // Expected outputs, updated on the same edges as the unit
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {e_v, e_cy, e_ov, e_res} = '0;
        end else if (clk_en) begin
            e_v = 1'b0;
            if (sync_clr) begin
                {e_cy, e_ov, e_res} = '0;
            end else begin
                if (vld) begin
                    r = model(code, $signed(a), $signed(b), $signed(la), $signed(lb), ci, cy, ov, w);
                    {e_v, e_res, e_c} = {1'b1, 32'(r), 32'(code)};
                end
                if (vld && w) {e_cy, e_ov} = {cy, ov};
                else if (fw) {e_cy, e_ov} = {cw, ow};
            end
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Outputs are settled half a cycle after the launching edge
    always @(negedge mclk) begin
        chk("RES_VALID", res_v, e_v);
        chk("CARRY", carry, e_cy);
        chk("OVERFLOW", ovf, e_ov);
        if (e_c < 9) chk("RES", res, e_res);
        else if (e_c < 15) chk("RES", res, e_res);
        else if (e_c < 23) chk("RES", res, e_res);
        else chk("RES", res, e_res);
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Random freezes and clears stress the hold and priority paths
    always @(posedge mclk) begin
        if (rnd_ctl) begin
            clk_en <= ($urandom_range(0, 15) != 0);
            sync_clr <= ($urandom_range(0, 31) == 0);
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end

    initial begin
        {rst_n, clk_en, sync_clr, rnd_ctl, mismatches, checks_done, e_c} = '0;
        clk_en = 1'b1;
        void'($urandom(32'h58fe));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // Every code against every pair of extreme operands, back to back
        for (int c = 0; c < 32; c++)
            for (int i = 0; i < 16; i++)
                u_iss.issue(5'(c), cs[i % 4], cs[i / 4], cl[i % 4], cl[i / 4], 4'(i));
        u_iss.idle();
        $display("corner test done");
        rnd_ctl = 1'b1;
        // Operands shifted by random amounts reach both the linear and the clamped regions
        for (int k = 0; k < 2000; k++) begin
            if ($urandom_range(0, 3) == 0) u_iss.idle();
            else u_iss.issue(5'($urandom), 16'($signed(16'($urandom)) >>> $urandom_range(0, 15)),
                             16'($signed(16'($urandom)) >>> $urandom_range(0, 15)),
                             32'($signed($urandom) >>> $urandom_range(0, 31)),
                             32'($signed($urandom) >>> $urandom_range(0, 31)), 4'($urandom));
            if (k == 1000) rst_n <= 1'b0;
            if (k == 1004) rst_n <= 1'b1;
        end
        rnd_ctl = 1'b0;
        u_iss.idle();
        {clk_en, sync_clr} <= 2'b10;
        repeat (3) u_iss.idle();
        $display("random test done");
        end_of_test();
    end
endmodule : tb_top

// ===== logic/sfa_alu.sv
`timescale 1ns/10ps
// What this block does
// - Signed 16 and 32 bit operands
// - Short saturating add
// - Short saturating subtract
// - Short absolute value, minimum gives maximum
// - Short left shift, signed count, saturating
// - Short right shift, signed count, saturating
// - Short negate equals zero minus operand
// - Short signed max and min
// - Short normalise shift count
// - Long saturating add
// - Long saturating subtract
// - Long negate saturates
// - Long left shift, signed count, saturating
// - Long right shift, signed count, saturating
// - Long normalise shift count
// - Fractional product doubled with saturation
// - Integer product without shift
// - Scaled product, shift right fifteen
// - Rounded scaled product adds 16384 first
// - Fractional multiply accumulate and deduct, saturating
// - Integer multiply accumulate and deduct, saturating
// - Wrapping accumulate updates carry and overflow
// - Rounded accumulate returns rounded upper half
// - High and low half extraction
// - Round to short with saturation
module sfa_alu (
    input wire logic MCLK, // 20 MHz clock
    input wire logic RST_N, // Asynchronous reset, active low
    input wire logic CLK_EN, // Freezes all state when low
    input wire logic SYNC_CLR, // Synchronous clear of result and flags
    input wire logic OP_VALID, // Operation strobe
    input wire logic [4:0] OP_CODE, // Operation code
    input wire logic [15:0] OPA, // Short operand one
    input wire logic [15:0] OPB, // Short operand two, or shift count
    input wire logic [31:0] LOPA, // Long operand or accumulator
    input wire logic [31:0] LOPB, // Long operand two
    input wire logic CARRY_IN, // Carry used by the wrapping accumulate
    input wire logic FLAG_WR, // Writes the carry and overflow flags
    input wire logic CARRY_WR, // Carry value to write
    input wire logic OVF_WR, // Overflow value to write
    output logic RES_VALID, // Result valid pulse
    output logic [31:0] RES, // Result, short results sign extended
    output logic CARRY, // Carry flag
    output logic OVERFLOW // Overflow flag
);
    typedef struct packed {
        logic valid;
        logic [31:0] res;
        logic carry;
        logic ovf;
    } sfa_state_t;

    sfa_state_t st_reg;
    sfa_state_t st_next;
    logic signed [31:0] prod;
    logic [15:0] mul_a;
    logic [15:0] mul_b;

    // Saturate a 33-bit sum to 32 bits
    function automatic logic [31:0] sat32(input logic [32:0] s);
        if (s[32] != s[31]) begin
            sat32 = s[32] ? sfa_pkg::L_MIN : sfa_pkg::L_MAX;
        end else begin
            sat32 = s[31:0];
        end
    endfunction : sat32

    // Saturating long add or subtract
    function automatic logic [31:0] ladd(input logic [31:0] a, input logic [31:0] b, input logic sub);
        logic [32:0] s;
        if (sub) begin
            s = {a[31], a} - {b[31], b};
        end else begin
            s = {a[31], a} + {b[31], b};
        end
        ladd = sat32(s);
    endfunction : ladd

    // Saturate a long value to a short
    function automatic logic [15:0] sat16(input logic [31:0] v);
        if ($signed(v) > $signed({{16{1'b0}}, sfa_pkg::S_MAX})) begin
            sat16 = sfa_pkg::S_MAX;
        end else if ($signed(v) < $signed({{16{1'b1}}, sfa_pkg::S_MIN})) begin
            sat16 = sfa_pkg::S_MIN;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // Saturating long shift, positive count left, negative right
    function automatic logic [31:0] lshl(input logic [31:0] v, input logic [15:0] cnt);
        logic signed [15:0] c;
        logic signed [63:0] w;
        c = $signed(cnt);
        w = 64'($signed(v));
        if (c < 0) begin
            lshl = (c <= -16'sd31) ? {32{v[31]}} : 32'($signed(v) >>> (-c));
        end else if (c >= 16'sd32) begin
            lshl = (v == '0) ? '0 : (v[31] ? sfa_pkg::L_MIN : sfa_pkg::L_MAX);
        end else begin
            w = w <<< c;
            lshl = ($signed(w) > 64'sd2147483647) ? sfa_pkg::L_MAX :
                   ($signed(w) < -64'sd2147483648) ? sfa_pkg::L_MIN : w[31:0];
        end
    endfunction : lshl

    // Negate a shift count
    function automatic logic [15:0] neg_cnt(input logic [15:0] c);
        neg_cnt = (c == sfa_pkg::S_MIN) ? sfa_pkg::S_MAX : 16'(-c);
    endfunction : neg_cnt

    // Leading sign bits of a long value, zero for zero
    function automatic logic [15:0] norm32(input logic [31:0] v);
        logic [31:0] x;
        norm32 = '0;
        x = v[31] ? ~v : v;
        if (v != '0 && v != '1) begin
            for (int i = 30; i >= 0; i--) begin
                if (x[i]) begin
                    norm32 = '0;
                    break;
                end
                norm32 = 16'(31 - i);
            end
            norm32 = '0;
            for (int i = 0; i <= 30; i++) begin
                if (x[i]) begin
                    norm32 = 16'(30 - i);
                end
            end
        end else if (v == '1) begin
            norm32 = 16'h001f;
        end
    endfunction : norm32

    function automatic logic [31:0] sx(input logic [15:0] v);
        sx = {{16{v[15]}}, v};
    endfunction : sx

    // Shared multiplier operands; shift count forms never use it
    assign mul_a = OPA;
    assign mul_b = OPB;

    sfa_mul u_mul (
        .a(mul_a),
        .b(mul_b),
        .p(prod)
    );

    // Next state: one operation per valid strobe
    always_comb begin
        logic [31:0] frac;
        logic [31:0] acc;
        logic [32:0] wsum;
        logic [31:0] addend;
        logic [15:0] n;
        // Doubling saturates only for -32768 squared
        frac = (prod == 32'sh40000000) ? sfa_pkg::L_MAX : 32'(prod <<< 1);
        acc = '0;
        wsum = '0;
        addend = '0;
        n = '0;
        st_next = st_reg;
        st_next.valid = 1'b0;
        if (FLAG_WR) begin
            st_next.carry = CARRY_WR;
            st_next.ovf = OVF_WR;
        end
        if (OP_VALID) begin
            st_next.valid = 1'b1;
            unique case (sfa_pkg::sfa_op_t'(OP_CODE))
                sfa_pkg::OP_ADD: st_next.res = sx(sat16(sx(OPA) + sx(OPB)));
                sfa_pkg::OP_SUB: st_next.res = sx(sat16(sx(OPA) - sx(OPB)));
                sfa_pkg::OP_ABS: st_next.res = sx(sat16(OPA[15] ? 32'(-sx(OPA)) : sx(OPA)));
                sfa_pkg::OP_NEG: st_next.res = sx(sat16(32'(-sx(OPA))));
                sfa_pkg::OP_SHL: st_next.res = sx(sat16(lshl(sx(OPA), OPB)));
                sfa_pkg::OP_SHR: st_next.res = sx(sat16(lshl(sx(OPA), neg_cnt(OPB))));
                sfa_pkg::OP_MAX: st_next.res = ($signed(OPA) > $signed(OPB)) ? sx(OPA) : sx(OPB);
                sfa_pkg::OP_MIN: st_next.res = ($signed(OPA) < $signed(OPB)) ? sx(OPA) : sx(OPB);
                sfa_pkg::OP_NORM: begin
                    // Short count is the long count less the 16 sign copies
                    n = norm32(sx(OPA));
                    st_next.res = (OPA == '0) ? '0 : sx(16'(n - 16'(sfa_pkg::HALF)));
                end
                sfa_pkg::OP_LADD: st_next.res = ladd(LOPA, LOPB, 1'b0);
                sfa_pkg::OP_LSUB: st_next.res = ladd(LOPA, LOPB, 1'b1);
                sfa_pkg::OP_LNEG: st_next.res = ladd('0, LOPA, 1'b1);
                sfa_pkg::OP_LSHL: st_next.res = lshl(LOPA, OPB);
                sfa_pkg::OP_LSHR: st_next.res = lshl(LOPA, neg_cnt(OPB));
                sfa_pkg::OP_LNORM: st_next.res = sx(norm32(LOPA));
                sfa_pkg::OP_FRAC_PRODUCT: st_next.res = frac;
                sfa_pkg::OP_INT_PRODUCT32: st_next.res = prod;
                sfa_pkg::OP_MULT: begin
                    acc = 32'(prod >>> sfa_pkg::MULT_SHIFT);
                    st_next.res = sx(sat16(acc));
                end
                sfa_pkg::OP_MULT_ROUND: begin
                    acc = 32'((prod + $signed(sfa_pkg::MULT_RND)) >>> sfa_pkg::MULT_SHIFT);
                    st_next.res = sx(sat16(acc));
                end
                sfa_pkg::OP_MAC: st_next.res = ladd(LOPA, frac, 1'b0);
                sfa_pkg::OP_MSU: st_next.res = ladd(LOPA, frac, 1'b1);
                sfa_pkg::OP_INT_ACCUMULATE: st_next.res = ladd(LOPA, prod, 1'b0);
                sfa_pkg::OP_INT_DEDUCT: st_next.res = ladd(LOPA, prod, 1'b1);
                sfa_pkg::OP_WRAPPING_ACCUMULATE, sfa_pkg::OP_WRAPPING_DEDUCT: begin
                    // Carry-in counts as a borrow complement when deducting
                    addend = (sfa_pkg::sfa_op_t'(OP_CODE) == sfa_pkg::OP_WRAPPING_DEDUCT) ? ~frac : frac;
                    wsum = {1'b0, LOPA} + {1'b0, addend} + 33'(CARRY_IN);
                    st_next.res = wsum[31:0];
                    st_next.carry = wsum[32];
                    st_next.ovf = (LOPA[31] == addend[31]) && (wsum[31] != LOPA[31]);
                end
                sfa_pkg::OP_MAC_ROUND: begin
                    acc = ladd(ladd(LOPA, frac, 1'b0), sfa_pkg::LONG_RND, 1'b0);
                    st_next.res = sx(acc[31:16]);
                end
                sfa_pkg::OP_MSU_ROUND: begin
                    acc = ladd(ladd(LOPA, frac, 1'b1), sfa_pkg::LONG_RND, 1'b0);
                    st_next.res = sx(acc[31:16]);
                end
                sfa_pkg::OP_HIGH_HALF: st_next.res = sx(LOPA[31:16]);
                sfa_pkg::OP_LOW_HALF: st_next.res = sx(LOPA[15:0]);
                sfa_pkg::OP_ROUND_TO_SHORT: begin
                    acc = ladd(LOPA, sfa_pkg::LONG_RND, 1'b0);
                    st_next.res = sx(acc[31:16]);
                end
                default: st_next.res = '0; // Unused codes give zero
            endcase
        end
        if (SYNC_CLR) begin
            st_next = '0;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg <= '0;
        end else if (CLK_EN) begin
            st_reg <= st_next;
        end
    end

    assign RES_VALID = st_reg.valid;
    assign RES = st_reg.res;
    assign CARRY = st_reg.carry;
    assign OVERFLOW = st_reg.ovf;

    property p_valid_follows;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR) |=> RES_VALID;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("Result valid missing");

    property p_add_sat;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_ADD) && !OPA[15] && !OPB[15]
         && OPA[14] && OPB[14]) |=> (RES == 32'h00007fff);
    endproperty
    a_add_sat: assert property (p_add_sat) else $error("Short add not saturated");

    property p_abs_min;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_ABS) && OPA == sfa_pkg::S_MIN)
        |=> (RES == 32'h00007fff);
    endproperty
    a_abs_min: assert property (p_abs_min) else $error("Absolute of minimum wrong");

    property p_frac_min;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_FRAC_PRODUCT)
         && OPA == sfa_pkg::S_MIN && OPB == sfa_pkg::S_MIN) |=> (RES == sfa_pkg::L_MAX);
    endproperty
    a_frac_min: assert property (p_frac_min) else $error("Fractional product not saturated");

    property p_int_prod;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_INT_PRODUCT32))
        |=> (RES == $past(prod));
    endproperty
    a_int_prod: assert property (p_int_prod) else $error("Integer product wrong");

    property p_lneg_min;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_LNEG) && LOPA == sfa_pkg::L_MIN)
        |=> (RES == sfa_pkg::L_MAX);
    endproperty
    a_lneg_min: assert property (p_lneg_min) else $error("Long negate wrapped");

    property p_high_half;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_HIGH_HALF))
        |=> (RES[15:0] == $past(LOPA[31:16]));
    endproperty
    a_high_half: assert property (p_high_half) else $error("High half wrong");

    property p_clear;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && SYNC_CLR) |=> (!RES_VALID && !CARRY && !OVERFLOW && RES == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("Synchronous clear failed");

    // Both operands far apart in sign always overflow the short range
    property p_sub_sat;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_SUB) && !OPA[15] && OPA[14]
         && OPB[15] && !OPB[14]) |=> (RES == 32'h00007fff);
    endproperty
    a_sub_sat: assert property (p_sub_sat) else $error("Short subtract not saturated");

    property p_neg_min;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_NEG) && OPA == sfa_pkg::S_MIN)
        |=> (RES == 32'h00007fff);
    endproperty
    a_neg_min: assert property (p_neg_min) else $error("Short negate of minimum wrong");

    // Checked by ordering, not by repeating the selection logic
    property p_max_pick;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_MAX))
        |=> ($signed(RES[15:0]) >= $signed($past(OPA)) && $signed(RES[15:0]) >= $signed($past(OPB))
             && (RES[15:0] == $past(OPA) || RES[15:0] == $past(OPB)) && RES[31:16] == {16{RES[15]}});
    endproperty
    a_max_pick: assert property (p_max_pick) else $error("Short maximum wrong");

    property p_ladd_sat;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OP_CODE == 5'(sfa_pkg::OP_LADD) && !LOPA[31] && LOPA[30]
         && !LOPB[31] && LOPB[30]) |=> (RES == sfa_pkg::L_MAX);
    endproperty
    a_ladd_sat: assert property (p_ladd_sat) else $error("Long add not saturated");

    // The scaled square of the minimum would wrap without the clamp
    property p_mult_min;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && OP_VALID && !SYNC_CLR && OPA == sfa_pkg::S_MIN && OPB == sfa_pkg::S_MIN
         && (OP_CODE == 5'(sfa_pkg::OP_MULT) || OP_CODE == 5'(sfa_pkg::OP_MULT_ROUND))) |=> (RES == 32'h00007fff);
    endproperty
    a_mult_min: assert property (p_mult_min) else $error("Scaled product not saturated");

    property p_flag_write;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && FLAG_WR && !OP_VALID && !SYNC_CLR)
        |=> (CARRY == $past(CARRY_WR) && OVERFLOW == $past(OVF_WR));
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("Flag write lost");

    property p_no_op;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && CLK_EN && !OP_VALID) |=> !RES_VALID;
    endproperty
    a_no_op: assert property (p_no_op) else $error("Result valid without operation");

    property p_freeze;
        @(posedge MCLK) disable iff (!RST_N)
        (RST_N && !CLK_EN) |=> ($stable(RES) && $stable(RES_VALID) && $stable(CARRY) && $stable(OVERFLOW));
    endproperty
    a_freeze: assert property (p_freeze) else $error("State changed while frozen");
endmodule : sfa_alu

// ===== logic/sfa_mul.sv
`timescale 1ns/10ps
// Single shared 16x16 signed multiplier, combinational
module sfa_mul (
    input wire logic signed [15:0] a, // Short operand
    input wire logic signed [15:0] b, // Short operand
    output logic signed [31:0] p // Full product
);
    // Only -32768 squared reaches 2^30; the caller clamps its doubled and scaled forms
    assign p = 32'(a * b);
endmodule : sfa_mul

// ===== logic/sfa_pkg.sv
package sfa_pkg;
    localparam int SW = 16;
    localparam int LW = 32;
    localparam logic [15:0] S_MAX = 16'h7fff;
    localparam logic [15:0] S_MIN = 16'h8000;
    localparam logic [31:0] L_MAX = 32'h7fffffff;
    localparam logic [31:0] L_MIN = 32'h80000000;
    localparam logic [31:0] MULT_RND = 32'h00004000;
    localparam logic [31:0] LONG_RND = 32'h00008000;
    localparam int MULT_SHIFT = 15;
    localparam int HALF = 16;

    // Operation codes issued by the sequencer
    typedef enum logic [4:0] {
        OP_ADD, OP_SUB, OP_ABS, OP_SHL, OP_SHR, OP_NEG, OP_MAX, OP_MIN, OP_NORM,
        OP_LADD, OP_LSUB, OP_LNEG, OP_LSHL, OP_LSHR, OP_LNORM,
        OP_FRAC_PRODUCT, OP_INT_PRODUCT32, OP_MULT, OP_MULT_ROUND,
        OP_MAC, OP_MSU, OP_INT_ACCUMULATE, OP_INT_DEDUCT,
        OP_WRAPPING_ACCUMULATE, OP_WRAPPING_DEDUCT, OP_MAC_ROUND, OP_MSU_ROUND,
        OP_HIGH_HALF, OP_LOW_HALF, OP_ROUND_TO_SHORT
    } sfa_op_t;
endpackage : sfa_pkg
